// ### core/prc_consts.svh
// Constants for the port rate-limit and cable-diagnostic register bank.
// Assumes inclusion by the bank and its rate decoder only.
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PRC_ADDR_P1_PHY_SPECIAL  8'h1A
`define PRC_ADDR_P1_NO_RESULT    8'h1B
`define PRC_ADDR_P2_PRIO3_LIMIT  8'h29
`define PRC_ADDR_P2_PHY_SPECIAL  8'h2A
`define PRC_ADDR_P2_FAULT_LOW    8'h2B
`define PRC_ADDR_P3_PRIO3_LIMIT  8'h39
`define PRC_ADDR_P3_RSVD_SPECIAL 8'h3A
`define PRC_ADDR_P3_RSVD_RESULT  8'h3B

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PRC_BIT_NEAR_SHORT   7
`define PRC_BIT_OUTCOME_HI   6
`define PRC_BIT_OUTCOME_LO   5
`define PRC_BIT_TEST_START   4
`define PRC_BIT_FORCE_LINK   3
`define PRC_BIT_LOOPBACK     1
`define PRC_BIT_FAULT_MSB    0
`define PRC_LIMIT_RESET      8'h00
`define PRC_FAULT_RESET      9'h000
`define PRC_OUTCOME_NORMAL   2'h0
`define PRC_OUTCOME_OPEN     2'h1
`define PRC_OUTCOME_SHORT    2'h2
`define PRC_OUTCOME_FAILED   2'h3

// ****************************************************************
// Rate codes and rates
// ****************************************************************
`define PRC_CODE_ZERO        7'h00
`define PRC_CODE_MAX_100     7'h63
`define PRC_CODE_FULL_100    7'h64
`define PRC_CODE_SUB_FIRST   7'h65
`define PRC_CODE_SUB_LAST    7'h73
`define PRC_CODE_MAX_10      7'h09
`define PRC_CODE_FULL_10     7'h0A
`define PRC_KBPS_PER_MBPS    17'h003E8
`define PRC_KBPS_SUB_STEP    17'h00040
`define PRC_KBPS_FULL_100    17'h186A0
`define PRC_KBPS_FULL_10     17'h02710
`define PRC_IFG_BYTES        4'hC

`endif

// ### core/prc_pkg.sv
// Types shared by the port rate-limit and cable-diagnostic bank.
// Assumes nothing of its surroundings.
package prc_pkg;

  // Cable diagnostic progress of one PHY port.
  typedef enum logic {
    PRC_TEST_IDLE,
    PRC_TEST_RUN
  } prc_test_state_t;

endpackage

// ### core/prc_rate_decode.sv
// Rate-code decoder: turns a 7-bit rate code into a limit in kbit/s.
// Assumes the caller supplies the port speed and the gap-counting option.
`timescale 1ns/1ps
`default_nettype none
`include "prc_consts.svh"

module prc_rate_decode
  import prc_pkg::*;
(
  // Code and port conditions
  input  wire logic [6:0]  code_in,
  input  wire logic        fast_in,
  input  wire logic        ifg_in,
  // Decoded limit
  output logic      [16:0] kbps_out,
  output logic             full_out,
  output logic             defined_out,
  output logic      [3:0]  overhead_out
);

  // Codes outside the listed ranges decode as undefined with no rate.
  always_comb begin
    kbps_out    = 17'h00000;
    full_out    = 1'b0;
    defined_out = 1'b0;
    if (fast_in) begin
      if (code_in == `PRC_CODE_ZERO || code_in == `PRC_CODE_FULL_100) begin
        kbps_out    = `PRC_KBPS_FULL_100;
        full_out    = 1'b1;
        defined_out = 1'b1;
      end else if (code_in <= `PRC_CODE_MAX_100) begin
        kbps_out    = 17'(17'(code_in) * `PRC_KBPS_PER_MBPS);
        defined_out = 1'b1;
      end else if (code_in >= `PRC_CODE_SUB_FIRST &&
                   code_in <= `PRC_CODE_SUB_LAST) begin
        kbps_out    = 17'((17'(code_in) - 17'(`PRC_CODE_FULL_100)) *
                          `PRC_KBPS_SUB_STEP);
        defined_out = 1'b1;
      end
    end else begin
      if (code_in == `PRC_CODE_ZERO || code_in == `PRC_CODE_FULL_10) begin
        kbps_out    = `PRC_KBPS_FULL_10;
        full_out    = 1'b1;
        defined_out = 1'b1;
      end else if (code_in <= `PRC_CODE_MAX_10) begin
        kbps_out    = 17'(17'(code_in) * `PRC_KBPS_PER_MBPS);
        defined_out = 1'b1;
      end
    end
  end

  assign overhead_out = ifg_in ? `PRC_IFG_BYTES : 4'h0;

endmodule // prc_rate_decode
`default_nettype wire

// ### core/prc_regs.sv
// Per-port priority-3 ingress limits and PHY special/cable-test registers.
// Assumes the PHY analog test engine and both access ports share ref_clk_in.
// Operation
// - Ports 2 and 3 hold a 7-bit priority-3 ingress limit, resetting to 0.
// - On 100 Mbit ports, codes 1 to 0x63 limit to 1-99 Mbit/s.
// - On 100 Mbit ports, codes 0 and 0x64 mean full 100 Mbit/s.
// - On 10 Mbit ports, codes 1 to 0x09 limit to 1-9 Mbit/s.
// - On 10 Mbit ports, codes 0 and 0x0A mean full 10 Mbit/s.
// - On 100 Mbit ports, codes 0x65 to 0x73 give 64-960 kbit/s steps.
// - Each priority-3 ingress limit field, on ports 2 and 3, has its own instance of the code decoder.
// - Bit 7 reads 1 when the test finds a short under 10 m.
// - Bits 6-5 report normal, open, short or failed test outcome.
// - Writing 1 to bit 4 starts the test; it clears on completion.
// - Start bit reading 0 after a test means outcome and distance are valid.
// - Bit 1 set loops the port's received line back to its transmitter.
// - Fault count is 9 bits; its top bit reads in bit 0.
// - Low eight fault count bits read in the result register, reset 0.
// - Port 3 PHY addresses are reserved; port 1 lacks the result register.
// - Ports 1 and 2 PHY special registers are also reached over PHY management; the result register is not.
// - With gap counting set, 12 gap bytes per frame enter rate sums.
`timescale 1ns/1ps
`default_nettype none
`include "prc_consts.svh"

module prc_regs
  import prc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Management register interface
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  input  wire logic [7:0]       reg_wdata_in,
  output logic      [7:0]       reg_rdata_out,
  // PHY management interface, port select 0 is port 1, 1 is port 2
  input  wire logic             miim_port_in,
  input  wire logic             miim_wr_in,
  input  wire logic             miim_rd_in,
  input  wire logic [7:0]       miim_wdata_in,
  output logic      [7:0]       miim_rdata_out,
  // Rate limiter conditions, index 0 is port 2, 1 is port 3
  input  wire logic [1:0]       port_fast_in,
  input  wire logic [1:0]       count_ifg_in,
  // Priority-3 ingress limit, index 0 is port 2, 1 is port 3
  output logic      [1:0][16:0] prio3_kbps_out,
  output logic      [1:0]       prio3_full_out,
  output logic      [1:0]       prio3_defined_out,
  output logic      [1:0][3:0]  prio3_overhead_out,
  // Cable test engine, index 0 is port 1, 1 is port 2
  output logic      [1:0]       cable_start_out,
  input  wire logic [1:0]       cable_done_in,
  input  wire logic [1:0][1:0]  cable_outcome_in,
  input  wire logic [1:0]       cable_near_short_in,
  input  wire logic [1:0][8:0]  cable_fault_count_in,
  // PHY line controls, index 0 is port 1, 1 is port 2
  output logic      [1:0]       loopback_out,
  output logic      [1:0]       force_link_out
);

  // ****************************************************************
  // Priority-3 ingress limit registers
  // ****************************************************************
  logic [1:0][7:0] limit_q;
  logic [1:0][7:0] limit_addr;

  assign limit_addr[0] = `PRC_ADDR_P2_PRIO3_LIMIT;
  assign limit_addr[1] = `PRC_ADDR_P3_PRIO3_LIMIT;

  // ****************************************************************
  // PHY special control/status state
  // ****************************************************************
  prc_test_state_t [1:0] test_q;
  logic [1:0]            near_short_q;
  logic [1:0][1:0]       outcome_q;
  logic [1:0][8:0]       fault_q;
  logic [1:0]            force_q;
  logic [1:0]            loop_q;
  logic [1:0]            start_q;
  logic [1:0][7:0]       special_rd;
  logic [1:0][7:0]       special_addr;
  logic [1:0]            special_wr;
  logic [1:0][7:0]       special_wdata;

  assign special_addr[0] = `PRC_ADDR_P1_PHY_SPECIAL;
  assign special_addr[1] = `PRC_ADDR_P2_PHY_SPECIAL;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      logic [16:0] kbps;
      logic        full;
      logic        defined;
      logic [3:0]  overhead;
      logic        reg_hit;
      logic        miim_hit;

      // The limit register stores bit 7 as written; only bits 6-0 act.
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          limit_q[gi] <= `PRC_LIMIT_RESET;
        end else if (reg_wr_in && reg_addr_in == limit_addr[gi]) begin
          limit_q[gi] <= reg_wdata_in;
        end
      end

      prc_rate_decode u_decode (
        .code_in      (limit_q[gi][6:0]),
        .fast_in      (port_fast_in[gi]),
        .ifg_in       (count_ifg_in[gi]),
        .kbps_out     (kbps),
        .full_out     (full),
        .defined_out  (defined),
        .overhead_out (overhead)
      );

      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          prio3_kbps_out[gi]     <= 17'h00000;
          prio3_full_out[gi]     <= 1'b0;
          prio3_defined_out[gi]  <= 1'b0;
          prio3_overhead_out[gi] <= 4'h0;
        end else begin
          prio3_kbps_out[gi]     <= kbps;
          prio3_full_out[gi]     <= full;
          prio3_defined_out[gi]  <= defined;
          prio3_overhead_out[gi] <= overhead;
        end
      end

      // The register interface wins when both ports write in one cycle.
      assign reg_hit  = reg_wr_in && reg_addr_in == special_addr[gi];
      assign miim_hit = miim_wr_in && miim_port_in == 1'(gi);
      assign special_wr[gi]    = reg_hit || miim_hit;
      assign special_wdata[gi] = reg_hit ? reg_wdata_in : miim_wdata_in;

      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          force_q[gi] <= 1'b0;
          loop_q[gi]  <= 1'b0;
        end else if (special_wr[gi]) begin
          force_q[gi] <= special_wdata[gi][`PRC_BIT_FORCE_LINK];
          loop_q[gi]  <= special_wdata[gi][`PRC_BIT_LOOPBACK];
        end
      end

      // A fresh start written in the completion cycle wins over the
      // self-clear, so a back-to-back request is never lost.
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          test_q[gi] <= PRC_TEST_IDLE;
        end else begin
          case (test_q[gi])
            PRC_TEST_IDLE: begin
              if (special_wr[gi] &&
                  special_wdata[gi][`PRC_BIT_TEST_START]) begin
                test_q[gi] <= PRC_TEST_RUN;
              end
            end
            PRC_TEST_RUN: begin
              if (cable_done_in[gi] && !(special_wr[gi] &&
                  special_wdata[gi][`PRC_BIT_TEST_START])) begin
                test_q[gi] <= PRC_TEST_IDLE;
              end
            end
            default: test_q[gi] <= PRC_TEST_IDLE;
          endcase
        end
      end

      // Launch pulse for the engine on every accepted start write.
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          cable_start_out[gi] <= 1'b0;
        end else begin
          cable_start_out[gi] <= special_wr[gi] &&
                                 special_wdata[gi][`PRC_BIT_TEST_START] &&
                                 (test_q[gi] == PRC_TEST_IDLE ||
                                  cable_done_in[gi]);
        end
      end

      // Results are captured only at completion, so they stay stable
      // while software polls the start bit.
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          near_short_q[gi] <= 1'b0;
          outcome_q[gi]    <= `PRC_OUTCOME_NORMAL;
          fault_q[gi]      <= `PRC_FAULT_RESET;
        end else if (test_q[gi] == PRC_TEST_RUN && cable_done_in[gi]) begin
          near_short_q[gi] <= cable_near_short_in[gi];
          outcome_q[gi]    <= cable_outcome_in[gi];
          fault_q[gi]      <= cable_fault_count_in[gi];
        end
      end

      assign start_q[gi] = test_q[gi] == PRC_TEST_RUN;

      always_comb begin
        special_rd[gi] = 8'h00;
        special_rd[gi][`PRC_BIT_NEAR_SHORT] = near_short_q[gi];
        special_rd[gi][`PRC_BIT_OUTCOME_HI:`PRC_BIT_OUTCOME_LO] =
          outcome_q[gi];
        special_rd[gi][`PRC_BIT_TEST_START] = start_q[gi];
        special_rd[gi][`PRC_BIT_FORCE_LINK] = force_q[gi];
        special_rd[gi][`PRC_BIT_LOOPBACK]   = loop_q[gi];
        special_rd[gi][`PRC_BIT_FAULT_MSB]  = fault_q[gi][8];
      end
    end
  endgenerate

  assign loopback_out   = loop_q;
  assign force_link_out = force_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Reserved port 3 addresses, port 1's missing result register and
  // any unmapped address all read zero.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `PRC_ADDR_P2_PRIO3_LIMIT:  reg_rdata_out <= limit_q[0];
        `PRC_ADDR_P3_PRIO3_LIMIT:  reg_rdata_out <= limit_q[1];
        `PRC_ADDR_P1_PHY_SPECIAL:  reg_rdata_out <= special_rd[0];
        `PRC_ADDR_P2_PHY_SPECIAL:  reg_rdata_out <= special_rd[1];
        `PRC_ADDR_P2_FAULT_LOW:    reg_rdata_out <= fault_q[1][7:0];
        `PRC_ADDR_P1_NO_RESULT:    reg_rdata_out <= 8'h00;
        `PRC_ADDR_P3_RSVD_SPECIAL: reg_rdata_out <= 8'h00;
        `PRC_ADDR_P3_RSVD_RESULT:  reg_rdata_out <= 8'h00;
        default:                   reg_rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      miim_rdata_out <= 8'h00;
    end else if (miim_rd_in) begin
      miim_rdata_out <= special_rd[miim_port_in];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_p2_start_write;
    reg_wr_in && reg_addr_in == `PRC_ADDR_P2_PHY_SPECIAL &&
      reg_wdata_in[`PRC_BIT_TEST_START] && test_q[1] == PRC_TEST_IDLE;
  endsequence

  sequence s_p2_launched;
    cable_start_out[1] && start_q[1];
  endsequence

  limit_write_a: assert property (
    reg_wr_in && reg_addr_in == `PRC_ADDR_P3_PRIO3_LIMIT
      |=> limit_q[1] == $past(reg_wdata_in))
    else $error("Port 3 limit did not take the written value");

  full_rate_a: assert property (
    port_fast_in[0] && $stable(port_fast_in[0]) &&
      limit_q[0][6:0] == `PRC_CODE_FULL_100
      |=> prio3_full_out[0] && prio3_kbps_out[0] == `PRC_KBPS_FULL_100)
    else $error("Code 0x64 did not give full 100 Mbit rate");

  slow_mbps_a: assert property (
    !port_fast_in[1] && limit_q[1][6:0] == `PRC_CODE_MAX_10
      |=> prio3_kbps_out[1] == 17'h02328 && prio3_defined_out[1])
    else $error("10 Mbit code 9 did not give 9000 kbit/s");

  sub_mbps_a: assert property (
    port_fast_in[0] && limit_q[0][6:0] == `PRC_CODE_SUB_LAST
      |=> prio3_kbps_out[0] == 17'h003C0)
    else $error("Code 0x73 did not give 960 kbit/s");

  test_launch_a: assert property (
    s_p2_start_write |=> s_p2_launched ##1 !cable_start_out[1])
    else $error("Start write did not launch a one-cycle test pulse");

  test_done_a: assert property (
    start_q[1] && cable_done_in[1] && !special_wr[1]
      |=> !start_q[1] && outcome_q[1] == $past(cable_outcome_in[1]) &&
          fault_q[1] == $past(cable_fault_count_in[1]))
    else $error("Completion did not clear start and latch results");

  result_hold_a: assert property (
    !(test_q[1] == PRC_TEST_RUN && cable_done_in[1]) |=> $stable(fault_q[1]))
    else $error("Fault count changed outside a completion");

  fault_read_a: assert property (
    reg_rd_in && reg_addr_in == `PRC_ADDR_P2_FAULT_LOW &&
      !(start_q[1] && cable_done_in[1])
      |=> reg_rdata_out == fault_q[1][7:0])
    else $error("Result register did not return the fault count");

  reserved_read_a: assert property (
    reg_rd_in && (reg_addr_in == `PRC_ADDR_P3_RSVD_SPECIAL ||
      reg_addr_in == `PRC_ADDR_P1_NO_RESULT) |=> reg_rdata_out == 8'h00)
    else $error("Reserved address read was not zero");

  loopback_a: assert property (
    miim_wr_in && !miim_port_in &&
      !(reg_wr_in && reg_addr_in == `PRC_ADDR_P1_PHY_SPECIAL)
      |=> loopback_out[0] == $past(miim_wdata_in[`PRC_BIT_LOOPBACK]))
    else $error("PHY management write did not steer port 1 loopback");

  ifg_bytes_a: assert property (
    count_ifg_in[1] |=> prio3_overhead_out[1] == `PRC_IFG_BYTES)
    else $error("Gap counting did not add 12 bytes");

endmodule // prc_regs
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the priority-3 limit and cable-test register bank.
// Assumes prc_regs is driven directly; the bench plays the test engine too.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import prc_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic             ref_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic [7:0]       reg_addr_in = 8'h00;
  logic             reg_wr_in = 1'b0;
  logic             reg_rd_in = 1'b0;
  logic [7:0]       reg_wdata_in = 8'h00;
  logic [7:0]       reg_rdata_out;
  logic             miim_port_in = 1'b0;
  logic             miim_wr_in = 1'b0;
  logic             miim_rd_in = 1'b0;
  logic [7:0]       miim_wdata_in = 8'h00;
  logic [7:0]       miim_rdata_out;
  logic [1:0]       port_fast_in = 2'h1;
  logic [1:0]       count_ifg_in = 2'h0;
  logic [1:0][16:0] prio3_kbps_out;
  logic [1:0]       prio3_full_out;
  logic [1:0]       prio3_defined_out;
  logic [1:0][3:0]  prio3_overhead_out;
  logic [1:0]       cable_start_out;
  logic [1:0]       cable_done_in = 2'h0;
  logic [1:0][1:0]  cable_outcome_in = '0;
  logic [1:0]       cable_near_short_in = 2'h0;
  logic [1:0][8:0]  cable_fault_count_in = '0;
  logic [1:0]       loopback_out;
  logic [1:0]       force_link_out;
  int               miscompares = 0;
  int               samples_checked = 0;
  int unsigned      cycles = 0;

  prc_regs dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .miim_port_in, .miim_wr_in, .miim_rd_in,
    .miim_wdata_in, .miim_rdata_out, .port_fast_in, .count_ifg_in,
    .prio3_kbps_out, .prio3_full_out, .prio3_defined_out,
    .prio3_overhead_out, .cable_start_out, .cable_done_in, .cable_outcome_in,
    .cable_near_short_in, .cable_fault_count_in, .loopback_out,
    .force_link_out);

  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************************************
  // Access tasks and comparisons
  // ****************************************************************
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hung wait would otherwise stall forever; the run needs under 1500.
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk_reg(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_out(input string n, input logic [16:0] e,
                         input logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask

  task automatic miim_write(input logic p, input logic [7:0] d);
    @(negedge ref_clk_in);
    miim_port_in = p;
    miim_wdata_in = d;
    miim_wr_in = 1'b1;
    @(negedge ref_clk_in);
    miim_wr_in = 1'b0;
  endtask

  task automatic miim_read(input logic p, output logic [7:0] d);
    @(negedge ref_clk_in);
    miim_port_in = p;
    miim_rd_in = 1'b1;
    @(negedge ref_clk_in);
    miim_rd_in = 1'b0;
    d = miim_rdata_out;
  endtask

  // Results are only promised in the done cycle, so they are scrambled after.
  task automatic pulse_done(input int p, input logic [1:0] oc,
                            input logic ns, input logic [8:0] fc);
    @(negedge ref_clk_in);
    cable_outcome_in[p] = oc;
    cable_near_short_in[p] = ns;
    cable_fault_count_in[p] = fc;
    cable_done_in[p] = 1'b1;
    @(negedge ref_clk_in);
    cable_done_in[p] = 1'b0;
    cable_outcome_in[p] = ~oc;
    cable_near_short_in[p] = ~ns;
    cable_fault_count_in[p] = ~fc;
  endtask

  // Returns {defined, full, kbps} for a code at the given port speed.
  function automatic logic [18:0] rate_exp(input logic [6:0] c,
                                           input logic f);
    if (f && (c == 7'h00 || c == 7'h64)) return {2'h3, 17'h186A0};
    if (f && c >= 7'h01 && c <= 7'h63) return {2'h2, 17'(c) * 17'h003E8};
    if (f && c >= 7'h65 && c <= 7'h73)
      return {2'h2, 17'(c - 7'h64) * 17'h00040};
    if (!f && (c == 7'h00 || c == 7'h0A)) return {2'h3, 17'h02710};
    if (!f && c >= 7'h01 && c <= 7'h09) return {2'h2, 17'(c) * 17'h003E8};
    return 19'h00000;
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  logic [6:0] codes [11] = '{7'h00, 7'h01, 7'h09, 7'h0A, 7'h0B, 7'h63,
                             7'h64, 7'h65, 7'h73, 7'h74, 7'h7F};
  logic [7:0] addrs [8] = '{8'h29, 8'h39, 8'h1A, 8'h2A, 8'h2B, 8'h3A,
                            8'h3B, 8'h1B};

  initial begin
    logic [7:0]  d;
    logic [18:0] e;
    logic [7:0]  last;
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    foreach (addrs[i]) begin
      reg_read(addrs[i], d);
      chk_reg("reset_value", 8'h00, d);
    end
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 2; s++) begin
        foreach (codes[i]) begin
          @(negedge ref_clk_in);
          port_fast_in[p] = s[0];
          count_ifg_in[p] = s[0];
          reg_write(p ? 8'h39 : 8'h29, {1'b0, codes[i]});
          @(negedge ref_clk_in);
          e = rate_exp(codes[i], s[0]);
          chk_out("kbps", e[16:0], prio3_kbps_out[p]);
          chk_out("full", {16'h0, e[17]}, {16'h0, prio3_full_out[p]});
          chk_out("defined", {16'h0, e[18]},
                  {16'h0, prio3_defined_out[p]});
          chk_out("ifg", s[0] ? 17'h0000C : 17'h00000,
                  {13'h0, prio3_overhead_out[p]});
          reg_read(p ? 8'h39 : 8'h29, d);
          chk_reg("limit", {1'b0, codes[i]}, d);
        end
      end
    end
    // Results of the previous test stay visible while a new one runs.
    last = 8'h00;
    for (int o = 0; o < 4; o++) begin
      reg_write(8'h2A, 8'h10);
      chk_out("start", 17'h00002, {15'h0, cable_start_out});
      reg_read(8'h2A, d);
      chk_reg("running", last | 8'h10, d);
      chk_out("start_end", 17'h00000, {15'h0, cable_start_out});
      pulse_done(1, o[1:0], o[1], {o[0], 8'hA5 ^ 8'(o)});
      d = 8'h10;
      while (d[4]) begin
        reg_read(8'h2A, d);
      end
      last = {o[1], o[1:0], 4'h0, o[0]};
      chk_reg("special", last, d);
      reg_read(8'h2B, d);
      chk_reg("fault_low", 8'hA5 ^ 8'(o), d);
    end
    pulse_done(1, 2'h0, 1'b0, 9'h000);
    reg_read(8'h2A, d);
    chk_reg("idle_done", 8'hE1, d);
    miim_write(1'b0, 8'h1A);
    chk_out("miim_start", 17'h00001, {15'h0, cable_start_out});
    chk_out("loop", 17'h00001, {15'h0, loopback_out});
    chk_out("force", 17'h00001, {15'h0, force_link_out});
    pulse_done(0, 2'h1, 1'b0, 9'h100);
    miim_read(1'b0, d);
    chk_reg("miim_special", 8'h2B, d);
    reg_read(8'h1A, d);
    chk_reg("p1_special", 8'h2B, d);
    reg_write(8'h2A, 8'h02);
    chk_out("loop2", 17'h00003, {15'h0, loopback_out});
    miim_read(1'b1, d);
    chk_reg("miim_p2", 8'hE3, d);
    reg_write(8'h1A, 8'h00);
    chk_out("loop_off", 17'h00002, {15'h0, loopback_out});
    chk_out("force_off", 17'h00000, {15'h0, force_link_out});
    reg_read(8'h1A, d);
    chk_reg("p1_cleared", 8'h21, d);
    foreach (addrs[i]) begin
      if (i >= 5) begin
        reg_write(addrs[i], 8'hFF);
        reg_read(addrs[i], d);
        chk_reg("reserved", 8'h00, d);
      end
    end
    reg_write(8'h7E, 8'hFF);
    reg_read(8'h7E, d);
    chk_reg("unmapped", 8'h00, d);
    test_done();
  end
endmodule // tb

`default_nettype wire
